// >>> fps_check.sv
// Holds the shared constants of the flash parameter checker and its check unit.
// Assumes the captured parameters stay stable while the check word is used.
`timescale 1ns/1ps

package fps_pkg;
   // ----------------------------------------------------------------
   // Block numbers and key
   // ----------------------------------------------------------------
   localparam int unsigned NUM_BLOCKS       = 16;
   localparam logic [7:0]  BLOCK_LAST_FULL  = 8'h0F;
   localparam logic [7:0]  BLOCK_LAST_SMALL = 8'h0B;
   localparam logic [7:0]  BLOCK_LAST_MID   = 8'h0D;
   localparam logic [7:0]  UNLOCK_KEY       = 8'h5A;
   // ----------------------------------------------------------------
   // Address area
   // ----------------------------------------------------------------
   localparam logic [31:0] FLASH_BASE_DEF   = 32'h0000_0000;
   localparam logic [31:0] FLASH_LAST_DEF   = 32'h0007_FFFF;
   localparam logic [31:0] ALIGN_MASK       = 32'h0000_007F;
   localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
   // ----------------------------------------------------------------
   // Result word layout
   // ----------------------------------------------------------------
   localparam int unsigned RES_SUCCESS_FAIL = 0;
   localparam int unsigned RES_DEST_ADDR    = 1;
   localparam int unsigned RES_SOURCE_ADDR  = 2;
   localparam int unsigned RES_BLOCK_RANGE  = 3;
   localparam int unsigned RES_KEY          = 4;
   localparam int unsigned RES_EXEC         = 5;
   localparam int unsigned RES_PROTECT      = 6;
   localparam logic [7:0]  RESULT_RESET     = 8'h00;
   localparam logic [7:0]  PROG_USED        = 8'h77;
   localparam logic [7:0]  ERASE_USED       = 8'h79;
   localparam logic [15:0] BLOCK_SEL_NONE   = 16'h0000;
   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_CHECK = 2'b01,
      ST_RUN   = 2'b11,
      ST_DONE  = 2'b10
   } fps_state_e;
endpackage

module fps_param_check #(
   parameter logic [31:0] FLASH_BASE = fps_pkg::FLASH_BASE_DEF,
   parameter logic [31:0] FLASH_LAST = fps_pkg::FLASH_LAST_DEF,
   parameter logic [7:0]  BLOCK_LAST = fps_pkg::BLOCK_LAST_FULL
) (
   // Captured parameters
   input  wire logic        op_erase,
   input  wire logic [31:0] src_addr,
   input  wire logic [31:0] dest_addr,
   input  wire logic [31:0] block_select,
   input  wire logic [7:0]  unlock_key,
   input  wire logic        protect_flag,
   // Check outcome
   output logic      [7:0]  check_word
);
   logic src_in_flash;
   logic dest_in_flash;

   assign src_in_flash  = (src_addr >= FLASH_BASE) && (src_addr <= FLASH_LAST);
   assign dest_in_flash = (dest_addr >= FLASH_BASE) && (dest_addr <= FLASH_LAST);

   // ----------------------------------------------------------------
   // Error bits and summary
   // ----------------------------------------------------------------
   always_comb begin
      check_word = fps_pkg::RESULT_RESET;
      if (!op_erase) begin
         check_word[fps_pkg::RES_SOURCE_ADDR] = src_in_flash; // RL1
         check_word[fps_pkg::RES_DEST_ADDR]   = !dest_in_flash // RL2
            || ((dest_addr & fps_pkg::ALIGN_MASK) != fps_pkg::ZERO_WORD); // RL3
      end else begin
         // Only the low byte carries the block number.
         check_word[fps_pkg::RES_BLOCK_RANGE] = block_select[7:0] > BLOCK_LAST; // RL7 RL8 RL9 RL11
      end
      check_word[fps_pkg::RES_KEY]          = unlock_key != fps_pkg::UNLOCK_KEY; // RL13
      check_word[fps_pkg::RES_PROTECT]      = protect_flag; // RL10
      check_word[fps_pkg::RES_SUCCESS_FAIL] = |check_word; // RL14
   end
endmodule

// >>> fps_program_erase.sv
// Holds the program and erase parameter sequencer with its result word.
// Assumes requests, key and error flag come from logic on the same clock.
`timescale 1ns/1ps

// Operation
// RL1: Source address inside flash sets bit 2.
// RL2: Destination outside flash sets bit 1.
// RL3: Destination not 128-byte aligned sets bit 1.
// RL4: Program bit 0 reports abnormal end.
// RL5: Requester places block number in parameter.
// RL6: Block number decodes to exactly one block.
// RL7: Block number above last block is error.
// RL8: Last valid block number is a parameter.
// RL9: Requester writes zeros to upper 24 bits.
// RL10: Bit 6 mirrors the flash error flag.
// RL11: Out-of-range block number sets erase bit 3.
// RL12: Erase bit 0 reports abnormal end.
// RL13: Key not 0x5A sets bit 4.
// RL14: Failed check skips array, sets bit 0.
// RL15: Unused result bits always read zero.
module fps_program_erase #(
   parameter logic [31:0] FLASH_BASE = fps_pkg::FLASH_BASE_DEF,
   parameter logic [31:0] FLASH_LAST = fps_pkg::FLASH_LAST_DEF,
   parameter logic [7:0]  BLOCK_LAST = fps_pkg::BLOCK_LAST_FULL
) (
   // Clock and reset
   input  wire logic        CLOCK,
   input  wire logic        RESET_N,
   // Requests and parameters
   input  wire logic        START_PROGRAM,
   input  wire logic        START_ERASE,
   input  wire logic [31:0] SOURCE_ADDR,
   input  wire logic [31:0] DEST_ADDR,
   input  wire logic [31:0] ERASE_BLOCK_SELECT,
   input  wire logic [7:0]  FLASH_UNLOCK_KEY,
   input  wire logic        FLASH_ERROR_FLAG,
   // Array engine
   output logic             ARRAY_START,
   output logic             ARRAY_ERASE,
   output logic      [31:0] ARRAY_SOURCE,
   output logic      [31:0] ARRAY_DEST,
   output logic      [15:0] ARRAY_BLOCK_SEL,
   input  wire logic        ARRAY_DONE,
   input  wire logic        ARRAY_FAIL,
   // Result
   output logic             BUSY,
   output logic             RESULT_VALID,
   output logic      [7:0]  PASS_FAIL_RESULT
);
   fps_pkg::fps_state_e state;
   fps_pkg::fps_state_e next_state;
   logic                op_erase;
   logic [31:0]         src_q;
   logic [31:0]         dst_q;
   logic [31:0]         ebs_q;
   logic [7:0]          key_q;
   logic                prot_q;
   logic [7:0]          check_word;
   logic [15:0]         next_block_sel;
   logic                start_any;

   assign start_any = START_PROGRAM || START_ERASE;

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   fps_param_check #(
      .FLASH_BASE (FLASH_BASE),
      .FLASH_LAST (FLASH_LAST),
      .BLOCK_LAST (BLOCK_LAST)
   ) u_check (
      .op_erase     (op_erase),
      .src_addr     (src_q),
      .dest_addr    (dst_q),
      .block_select (ebs_q),
      .unlock_key   (key_q),
      .protect_flag (prot_q),
      .check_word   (check_word)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      unique case (state)
         fps_pkg::ST_IDLE: begin
            if (start_any) begin
               next_state = fps_pkg::ST_CHECK;
            end
         end
         fps_pkg::ST_CHECK: begin
            if (check_word[fps_pkg::RES_SUCCESS_FAIL]) begin
               next_state = fps_pkg::ST_DONE; // RL14
            end else begin
               next_state = fps_pkg::ST_RUN;
            end
         end
         fps_pkg::ST_RUN: begin
            if (ARRAY_DONE) begin
               next_state = fps_pkg::ST_DONE;
            end
         end
         fps_pkg::ST_DONE: begin
            next_state = fps_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         state <= fps_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign BUSY         = state != fps_pkg::ST_IDLE;
   assign RESULT_VALID = state == fps_pkg::ST_DONE;

   // ----------------------------------------------------------------
   // Parameter capture
   // ----------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         op_erase <= 1'b0;
         src_q    <= fps_pkg::ZERO_WORD;
         dst_q    <= fps_pkg::ZERO_WORD;
         ebs_q    <= fps_pkg::ZERO_WORD;
         key_q    <= fps_pkg::RESULT_RESET;
         prot_q   <= 1'b0;
      end else if (state == fps_pkg::ST_IDLE && start_any) begin
         op_erase <= !START_PROGRAM;
         src_q    <= SOURCE_ADDR;
         dst_q    <= DEST_ADDR;
         ebs_q    <= ERASE_BLOCK_SELECT; // RL5
         key_q    <= FLASH_UNLOCK_KEY;
         prot_q   <= FLASH_ERROR_FLAG;
      end
   end

   assign ARRAY_ERASE  = op_erase;
   assign ARRAY_SOURCE = src_q;
   assign ARRAY_DEST   = dst_q;

   // ----------------------------------------------------------------
   // Block decode
   // ----------------------------------------------------------------
   for (genvar i = 0; i < fps_pkg::NUM_BLOCKS; i++) begin : g_block
      assign next_block_sel[i] = op_erase && (ebs_q[7:0] == 8'(i)); // RL6
   end

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         ARRAY_START     <= 1'b0;
         ARRAY_BLOCK_SEL <= fps_pkg::BLOCK_SEL_NONE;
      end else if (state == fps_pkg::ST_CHECK && !check_word[fps_pkg::RES_SUCCESS_FAIL]) begin
         ARRAY_START     <= 1'b1;
         ARRAY_BLOCK_SEL <= next_block_sel;
      end else begin
         ARRAY_START     <= 1'b0;
         ARRAY_BLOCK_SEL <= ARRAY_BLOCK_SEL;
      end
   end

   // ----------------------------------------------------------------
   // Result word
   // ----------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         PASS_FAIL_RESULT <= fps_pkg::RESULT_RESET;
      end else if (state == fps_pkg::ST_CHECK && check_word[fps_pkg::RES_SUCCESS_FAIL]) begin
         PASS_FAIL_RESULT <= check_word; // RL14 RL15
      end else if (state == fps_pkg::ST_RUN && ARRAY_DONE) begin
         PASS_FAIL_RESULT                            <= fps_pkg::RESULT_RESET;
         PASS_FAIL_RESULT[fps_pkg::RES_EXEC]         <= ARRAY_FAIL;
         PASS_FAIL_RESULT[fps_pkg::RES_SUCCESS_FAIL] <= ARRAY_FAIL; // RL4 RL12
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESET_N);

   logic a_src_in;
   logic a_dst_in;
   assign a_src_in = (src_q >= FLASH_BASE) && (src_q <= FLASH_LAST);
   assign a_dst_in = (dst_q >= FLASH_BASE) && (dst_q <= FLASH_LAST);

   sequence s_bad_check;
      state == fps_pkg::ST_CHECK && check_word[fps_pkg::RES_SUCCESS_FAIL];
   endsequence

   sequence s_fail_report;
      RESULT_VALID && !ARRAY_START && PASS_FAIL_RESULT[fps_pkg::RES_SUCCESS_FAIL];
   endsequence

   sequence s_prog_report;
      RESULT_VALID && !op_erase && !$past(ARRAY_DONE);
   endsequence

   a_source_in_flash: assert property ( // RL1
      s_prog_report |-> PASS_FAIL_RESULT[fps_pkg::RES_SOURCE_ADDR] == a_src_in)
      else $error("Source address error bit wrong.");

   a_dest_out_flash: assert property ( // RL2
      (s_prog_report and !a_dst_in) |-> PASS_FAIL_RESULT[fps_pkg::RES_DEST_ADDR])
      else $error("Destination range error not reported.");

   a_dest_align_err: assert property ( // RL3
      (s_prog_report and (dst_q[6:0] != 7'h00)) |-> PASS_FAIL_RESULT[fps_pkg::RES_DEST_ADDR])
      else $error("Destination alignment error not reported.");

   a_sf_summary: assert property ( // RL4
      RESULT_VALID |-> PASS_FAIL_RESULT[0] == (|PASS_FAIL_RESULT[7:1]))
      else $error("Success/fail bit disagrees with error bits.");

   a_exec_outcome: assert property ( // RL12
      state == fps_pkg::ST_RUN && ARRAY_DONE |=> RESULT_VALID
         && PASS_FAIL_RESULT[fps_pkg::RES_SUCCESS_FAIL] == $past(ARRAY_FAIL))
      else $error("Array outcome not reported next cycle.");

   a_block_onehot: assert property ( // RL6
      ARRAY_START && op_erase |-> $onehot(ARRAY_BLOCK_SEL) && ARRAY_BLOCK_SEL[ebs_q[3:0]])
      else $error("Erase block select not one-hot.");

   a_block_range: assert property ( // RL7
      RESULT_VALID && op_erase && !$past(ARRAY_DONE)
         |-> PASS_FAIL_RESULT[fps_pkg::RES_BLOCK_RANGE] == (ebs_q[7:0] > BLOCK_LAST))
      else $error("Erase block range error bit wrong.");

   a_protect_mirror: assert property ( // RL10
      start_any && state == fps_pkg::ST_IDLE && FLASH_ERROR_FLAG
         |-> ##2 RESULT_VALID && PASS_FAIL_RESULT[fps_pkg::RES_PROTECT])
      else $error("Protection state not reported.");

   a_key_check: assert property ( // RL13
      start_any && state == fps_pkg::ST_IDLE && FLASH_UNLOCK_KEY != fps_pkg::UNLOCK_KEY
         |-> ##2 RESULT_VALID && PASS_FAIL_RESULT[fps_pkg::RES_KEY] && !ARRAY_START)
      else $error("Key error not reported.");

   a_skip_on_error: assert property ( // RL14
      s_bad_check |=> s_fail_report)
      else $error("Array started despite failed check.");

   a_unused_zero: assert property ( // RL15
      RESULT_VALID |-> (PASS_FAIL_RESULT
         & ~(op_erase ? fps_pkg::ERASE_USED : fps_pkg::PROG_USED)) == fps_pkg::RESULT_RESET)
      else $error("Unused result bit set.");
endmodule

// >>> fps_program_erase_bench.sv
// Holds the self-checking bench of the program and erase parameter sequencer.
// Assumes the sequencer and its package are compiled first; the bench plays the array.
`timescale 1ns/1ps

module fps_program_erase_bench;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        CLOCK = 1'b0;
   logic        RESET_N = 1'b0;
   logic        START_PROGRAM = 1'b0;
   logic        START_ERASE = 1'b0;
   logic [31:0] SOURCE_ADDR = 32'h0000_0000;
   logic [31:0] DEST_ADDR = 32'h0000_0000;
   logic [31:0] ERASE_BLOCK_SELECT = 32'h0000_0000;
   logic [7:0]  FLASH_UNLOCK_KEY = 8'h00;
   logic        FLASH_ERROR_FLAG = 1'b0;
   logic        ARRAY_DONE = 1'b0;
   logic        ARRAY_FAIL = 1'b0;
   logic        ARRAY_START, ARRAY_ERASE, BUSY, RESULT_VALID;
   logic [31:0] ARRAY_SOURCE, ARRAY_DEST;
   logic [15:0] ARRAY_BLOCK_SEL;
   logic [7:0]  PASS_FAIL_RESULT, small_result;
   int          err_count = 0;
   int          n_compared = 0;

   always #5 CLOCK = ~CLOCK;

   fps_program_erase uut (.CLOCK(CLOCK), .RESET_N(RESET_N), .START_PROGRAM(START_PROGRAM),
      .START_ERASE(START_ERASE), .SOURCE_ADDR(SOURCE_ADDR), .DEST_ADDR(DEST_ADDR),
      .ERASE_BLOCK_SELECT(ERASE_BLOCK_SELECT), .FLASH_UNLOCK_KEY(FLASH_UNLOCK_KEY),
      .FLASH_ERROR_FLAG(FLASH_ERROR_FLAG), .ARRAY_START(ARRAY_START), .ARRAY_ERASE(ARRAY_ERASE),
      .ARRAY_SOURCE(ARRAY_SOURCE), .ARRAY_DEST(ARRAY_DEST), .ARRAY_BLOCK_SEL(ARRAY_BLOCK_SEL),
      .ARRAY_DONE(ARRAY_DONE), .ARRAY_FAIL(ARRAY_FAIL), .BUSY(BUSY),
      .RESULT_VALID(RESULT_VALID), .PASS_FAIL_RESULT(PASS_FAIL_RESULT));

   fps_program_erase #(.BLOCK_LAST(fps_pkg::BLOCK_LAST_SMALL)) uut_small (.CLOCK(CLOCK),
      .RESET_N(RESET_N), .START_PROGRAM(START_PROGRAM), .START_ERASE(START_ERASE),
      .SOURCE_ADDR(SOURCE_ADDR), .DEST_ADDR(DEST_ADDR), .ERASE_BLOCK_SELECT(ERASE_BLOCK_SELECT),
      .FLASH_UNLOCK_KEY(FLASH_UNLOCK_KEY), .FLASH_ERROR_FLAG(FLASH_ERROR_FLAG), .ARRAY_START(),
      .ARRAY_ERASE(), .ARRAY_SOURCE(), .ARRAY_DEST(), .ARRAY_BLOCK_SEL(), .ARRAY_DONE(ARRAY_DONE),
      .ARRAY_FAIL(ARRAY_FAIL), .BUSY(), .RESULT_VALID(), .PASS_FAIL_RESULT(small_result));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // One request; plays the array and compares the result word and block select.
   task automatic do_op(input logic er, input logic [31:0] s, d, b, input logic [7:0] k,
                        input logic f, fl, input logic [7:0] exp, input logic run,
                        input logic [15:0] sel);
      logic saw;
      saw = 1'b0;
      @(posedge CLOCK) #1;
      START_PROGRAM = ~er;
      START_ERASE = er;
      SOURCE_ADDR = s;
      DEST_ADDR = d;
      ERASE_BLOCK_SELECT = b;
      FLASH_UNLOCK_KEY = k;
      FLASH_ERROR_FLAG = f;
      @(posedge CLOCK) #1;
      START_PROGRAM = 1'b0;
      START_ERASE = 1'b0;
      chk(BUSY, 1'b1);
      for (int i = 0; i < 20 && RESULT_VALID !== 1'b1; i++) begin
         ARRAY_DONE = 1'b0;
         if (ARRAY_START === 1'b1) begin
            saw = 1'b1;
            chk(ARRAY_BLOCK_SEL, sel);
            chk(ARRAY_ERASE, er);
            chk(ARRAY_SOURCE, s);
            chk(ARRAY_DEST, d);
            ARRAY_DONE = 1'b1;
            ARRAY_FAIL = fl;
         end
         @(posedge CLOCK) #1;
      end
      ARRAY_DONE = 1'b0;
      chk(RESULT_VALID, 1'b1);
      chk(PASS_FAIL_RESULT, exp);
      chk(saw, run);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      chk(PASS_FAIL_RESULT, 8'h00);
      chk(BUSY, 1'b0);
      $display("reset test done");
   endtask

   task automatic t_prog_ok();
      do_op(0, 32'h0008_0000, 32'h0000_0080, 0, 8'h5A, 0, 0, 8'h00, 1, 16'h0000);
      do_op(0, 32'h0008_0000, 32'h0007_FF80, 0, 8'h5A, 0, 1, 8'h21, 1, 16'h0000);
      $display("program test done");
   endtask

   task automatic t_src_err();
      do_op(0, 32'h0007_FFFF, 32'h0000_0100, 0, 8'h5A, 0, 0, 8'h05, 0, 16'h0000);
      do_op(0, 32'h0000_0000, 32'h0000_0100, 0, 8'h5A, 0, 0, 8'h05, 0, 16'h0000);
      $display("source test done");
   endtask

   task automatic t_dest_err();
      do_op(0, 32'h0010_0000, 32'h0008_0000, 0, 8'h5A, 0, 0, 8'h03, 0, 16'h0000);
      do_op(0, 32'h0010_0000, 32'h0000_0101, 0, 8'h5A, 0, 0, 8'h03, 0, 16'h0000);
      do_op(0, 32'h0010_0000, 32'h0000_0040, 0, 8'h5A, 0, 0, 8'h03, 0, 16'h0000);
      $display("destination test done");
   endtask

   task automatic t_erase_blocks();
      for (int b = 0; b < 16; b++) begin
         do_op(1, 0, 0, b, 8'h5A, 0, 0, 8'h00, 1, 16'h0001 << b);
      end
      do_op(1, 0, 0, 32'h0000_0005, 8'h5A, 0, 1, 8'h21, 1, 16'h0020);
      $display("erase block test done");
   endtask

   task automatic t_erase_range();
      do_op(1, 0, 0, 32'h0000_0010, 8'h5A, 0, 0, 8'h09, 0, 16'h0000);
      do_op(1, 0, 0, 32'h0000_00FF, 8'h5A, 0, 0, 8'h09, 0, 16'h0000);
      do_op(1, 0, 0, 32'h0000_000C, 8'h5A, 0, 0, 8'h00, 1, 16'h1000);
      chk(small_result, 8'h09);
      $display("erase range test done");
   endtask

   task automatic t_key_protect();
      do_op(0, 32'h0010_0000, 32'h0000_0080, 0, 8'hA5, 0, 0, 8'h11, 0, 16'h0000);
      do_op(1, 0, 0, 32'h0000_0003, 8'h5B, 0, 0, 8'h11, 0, 16'h0000);
      do_op(1, 0, 0, 32'h0000_0003, 8'h5A, 1, 0, 8'h41, 0, 16'h0000);
      do_op(0, 32'h0010_0000, 32'h0000_0080, 0, 8'h5A, 1, 0, 8'h41, 0, 16'h0000);
      $display("key and protect test done");
   endtask

   // ----------------------------------------------------------------
   // Sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge CLOCK);
      #1 RESET_N = 1'b1;
      t_reset();
      t_prog_ok();
      t_src_err();
      t_dest_err();
      t_erase_blocks();
      t_erase_range();
      t_key_protect();
      wrap_up();
   end

   initial begin
      repeat (5000) @(posedge CLOCK);
      err_count++;
      wrap_up();
   end
endmodule
